// ---- include/cprc_pkg.sv ----
/*
 * Constants shared by the configuration memory readout control.
 * Assumes a 100 MHz core clock and an external configuration clock of at most a few MHz.
 */
package cprc_pkg;
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          RESET_HOLD_NS      = 200;
    localparam int          RESET_HOLD_CYC     = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CFG_PULSE_NS       = 500;
    localparam int          CFG_PULSE_CYC      = CFG_PULSE_NS / CLK_PERIOD_NS;
    localparam int          OSC_DIV_CYC        = 8;
    localparam int          ADDR_W             = 16;
    localparam logic [15:0] REV0_START         = 16'h0000;
    localparam logic [15:0] REV1_START         = 16'h0400;
    localparam logic [15:0] REV2_START         = 16'h0800;
    localparam logic [15:0] REV3_START         = 16'h0C00;
    localparam logic [15:0] TERMINAL_COUNT_RST = 16'h0FFF;
    localparam int          SYNC_RST           = 0;
endpackage : cprc_pkg

// ---- design/cprc_readout.sv ----
/*
 * Readout control: address counter, clock source choice, standby/reset tri-states,
 * open-drain reset and configuration pulse lines, revision selection and cascade output.
 * Assumes CFG_CLK, CHIP_SELECT_N, BUSY, OE_RESET_N_IN and CONFIG_PULSE_N_IN are asynchronous to CLOCK; the memory array answers combinationally on MEM_ADDR.
 */
`timescale 1ns/100ps
module cprc_readout
    import cprc_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic          CLOCK,
    input  wire logic          RST_N,
    input  wire logic          CFG_CLK,
    input  wire logic          CHIP_SELECT_N,
    input  wire logic          BUSY,
    input  wire logic          OE_RESET_N_IN,
    output logic               OE_RESET_N_OUT,
    output logic               OE_RESET_N_OE,
    input  wire logic          CONFIG_PULSE_N_IN,
    output logic               CONFIG_PULSE_N_OUT,
    output logic               CONFIG_PULSE_N_OE,
    input  wire logic          EXTERNAL_REV_PICK_ENABLE,
    input  wire logic          REVISION_PICK_BIT0,
    input  wire logic          REVISION_PICK_BIT1,
    input  wire logic [1:0]    INTERNAL_REV_PICK,
    input  wire logic          USE_INTERNAL_OSC,
    input  wire logic          PARALLEL_MODE,
    input  wire logic          CFG_CLOCK_OUT_ENABLE,
    input  wire logic          ISP_MODE_ACTIVE,
    input  wire logic          ISP_CLAMPED,
    input  wire logic          RECONFIGURE_CMD,
    input  wire logic [AW-1:0] TERMINAL_COUNT,
    output logic [AW-1:0]      MEM_ADDR,
    input  wire logic [7:0]    MEM_DATA,
    output logic               SERIAL_DATA_LINE_OUT,
    output logic               SERIAL_DATA_LINE_OE,
    output logic [6:0]         UPPER_DATA_LINES_OUT,
    output logic [6:0]         UPPER_DATA_LINES_OE,
    output logic               CFG_CLOCK_OUT,
    output logic               CFG_CLOCK_OUT_OE,
    output logic               CASCADE_ENABLE_OUT_N
);
    // Three-stage synchronisers; a change counts once stages two and three agree.
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, sv_q;
    logic [NSYNC-1:0] s1_d, s2_d, s3_d, sv_d, raw;
    logic             clk_s, cs_n_s, busy_s, oe_s, cf_s;
    logic             clk_prev_q, cf_prev_q, clk_prev_d, cf_prev_d;

    always_comb begin
        raw  = {CFG_CLK, CHIP_SELECT_N, BUSY, OE_RESET_N_IN, CONFIG_PULSE_N_IN};
        s1_d = raw;
        s2_d = s1_q;
        s3_d = s2_q;
        sv_d = sv_q;
        for (int i = 0; i < NSYNC; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                sv_d[i] = s3_q[i];
            end
        end
        {clk_s, cs_n_s, busy_s, oe_s, cf_s} = sv_q;
        clk_prev_d = clk_s;
        cf_prev_d  = cf_s;
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            s1_q       <= 5'h1B;
            s2_q       <= 5'h1B;
            s3_q       <= 5'h1B;
            sv_q       <= 5'h1B;
            clk_prev_q <= 1'b1;
            cf_prev_q  <= 1'b1;
        end else begin
            s1_q       <= s1_d;
            s2_q       <= s2_d;
            s3_q       <= s3_d;
            sv_q       <= sv_d;
            clk_prev_q <= clk_prev_d;
            cf_prev_q  <= cf_prev_d;
        end
    end

    function automatic logic [AW-1:0] rev_start(input logic [1:0] rev);
        case (rev)
            2'h0:    rev_start = AW'(REV0_START);
            2'h1:    rev_start = AW'(REV1_START);
            2'h2:    rev_start = AW'(REV2_START);
            default: rev_start = AW'(REV3_START);
        endcase
    endfunction : rev_start

    // Internal reset hold and reconfigure pulse timers.
    logic [7:0] rst_cnt_q, rst_cnt_d, cfp_cnt_q, cfp_cnt_d;
    logic       osc_q, osc_d, osc_prev_q, osc_prev_d;
    logic [3:0] div_q, div_d;

    always_comb begin
        rst_cnt_d = (rst_cnt_q != 8'h00) ? rst_cnt_q - 8'h01 : rst_cnt_q;
        cfp_cnt_d = (cfp_cnt_q != 8'h00) ? cfp_cnt_q - 8'h01 : cfp_cnt_q;
        if (RECONFIGURE_CMD) begin
            cfp_cnt_d = 8'(CFG_PULSE_CYC);
        end
        div_d      = (div_q == 4'(OSC_DIV_CYC - 1)) ? 4'h0 : div_q + 4'h1;
        osc_d      = (div_q == 4'(OSC_DIV_CYC - 1)) ? ~osc_q : osc_q;
        osc_prev_d = osc_q;
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rst_cnt_q  <= 8'(RESET_HOLD_CYC);
            cfp_cnt_q  <= 8'h00;
            div_q      <= 4'h0;
            osc_q      <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            rst_cnt_q  <= rst_cnt_d;
            cfp_cnt_q  <= cfp_cnt_d;
            div_q      <= div_d;
            osc_q      <= osc_d;
            osc_prev_q <= osc_prev_d;
        end
    end

    logic internal_reset;
    assign internal_reset     = rst_cnt_q != 8'h00;
    assign OE_RESET_N_OUT     = 1'b0;
    assign OE_RESET_N_OE      = internal_reset;
    assign CONFIG_PULSE_N_OUT = 1'b0;
    assign CONFIG_PULSE_N_OE  = cfp_cnt_q != 8'h00;

    // Counter, two-entry output buffer and cascade output.
    logic          src_edge, enabled, isp_block, advance, cf_rise;
    logic [1:0]    rev_pick;
    logic [AW-1:0] addr_q, addr_d;
    logic          tc_pass_q, tc_pass_d;
    logic [7:0]    buf_q [2];
    logic [7:0]    buf_d [2];
    logic [1:0]    cnt_q, cnt_d;
    logic [7:0]    dout_q, dout_d;

    always_comb begin
        rev_pick  = EXTERNAL_REV_PICK_ENABLE ? INTERNAL_REV_PICK
                                             : {REVISION_PICK_BIT1, REVISION_PICK_BIT0};
        src_edge  = USE_INTERNAL_OSC ? (osc_q && !osc_prev_q) : (clk_s && !clk_prev_q);
        cf_rise   = cf_s && !cf_prev_q;
        isp_block = ISP_MODE_ACTIVE;
        enabled   = !cs_n_s && oe_s;
        advance   = src_edge && enabled && cf_s && !isp_block
                    && !(PARALLEL_MODE && busy_s);
        addr_d    = addr_q;
        tc_pass_d = tc_pass_q;
        buf_d     = buf_q;
        cnt_d     = cnt_q;
        dout_d    = dout_q;
        // The buffer refills from the array only when a slot is free, so a held byte under busy is never lost.
        if (cnt_q != 2'h2 && enabled && !tc_pass_q && !isp_block) begin
            buf_d[cnt_q[0]] = MEM_DATA;
            cnt_d           = cnt_q + 2'h1;
            addr_d          = addr_q + 1'b1;
            if (addr_q == TERMINAL_COUNT) begin
                tc_pass_d = 1'b1;
            end
        end
        if (advance && cnt_q != 2'h0) begin
            dout_d   = buf_q[0];
            buf_d[0] = buf_d[1];
            if (cnt_d == cnt_q) begin
                cnt_d = cnt_q - 2'h1;
            end else begin
                buf_d[0] = (cnt_q == 2'h1) ? MEM_DATA : buf_q[1];
                cnt_d    = cnt_q;
            end
        end
        if (!enabled) begin
            addr_d    = '0;
            tc_pass_d = 1'b0;
            cnt_d     = 2'h0;
        end
        if (cf_rise) begin
            addr_d    = rev_start(rev_pick);
            tc_pass_d = 1'b0;
            cnt_d     = 2'h0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            addr_q    <= '0;
            tc_pass_q <= 1'b0;
            buf_q[0]  <= 8'h00;
            buf_q[1]  <= 8'h00;
            cnt_q     <= 2'h0;
            dout_q    <= 8'h00;
        end else begin
            addr_q    <= addr_d;
            tc_pass_q <= tc_pass_d;
            buf_q     <= buf_d;
            cnt_q     <= cnt_d;
            dout_q    <= dout_d;
        end
    end

    logic drive;
    assign drive                = enabled && !(ISP_MODE_ACTIVE && !ISP_CLAMPED);
    assign MEM_ADDR             = addr_q;
    assign SERIAL_DATA_LINE_OUT = dout_q[0];
    assign SERIAL_DATA_LINE_OE  = drive;
    assign UPPER_DATA_LINES_OUT = dout_q[7:1];
    assign UPPER_DATA_LINES_OE  = {7{drive && PARALLEL_MODE}};
    assign CFG_CLOCK_OUT        = USE_INTERNAL_OSC ? osc_q : clk_s;
    assign CFG_CLOCK_OUT_OE     = enabled && CFG_CLOCK_OUT_ENABLE;
    assign CASCADE_ENABLE_OUT_N = !(enabled && tc_pass_q && cnt_q == 2'h0);

    property p_upper_float;
        @(posedge CLOCK) disable iff (!RST_N) !PARALLEL_MODE |-> UPPER_DATA_LINES_OE == 7'h00;
    endproperty
    a_upper_float: assert property (p_upper_float) else $error("upper lines driven in serial mode");

    property p_no_adv_busy;
        @(posedge CLOCK) disable iff (!RST_N)
            PARALLEL_MODE && busy_s && enabled && !cf_rise |=> $stable(dout_q);
    endproperty
    a_no_adv_busy: assert property (p_no_adv_busy) else $error("byte changed while busy");

    // The enables follow the synchronised levels at once, the counter one cycle later.
    property p_reset_float;
        @(posedge CLOCK) disable iff (!RST_N)
            !oe_s && !cf_rise |-> (!SERIAL_DATA_LINE_OE && !CFG_CLOCK_OUT_OE) ##1 MEM_ADDR == '0;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("outputs not floated under reset line");

    property p_standby;
        @(posedge CLOCK) disable iff (!RST_N)
            cs_n_s && !cf_rise |-> (CASCADE_ENABLE_OUT_N && !CFG_CLOCK_OUT_OE) ##1 MEM_ADDR == '0;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not honoured");

    property p_rst_pull;
        @(posedge CLOCK) disable iff (!RST_N) $fell(internal_reset) |-> $past(OE_RESET_N_OE);
    endproperty
    a_rst_pull: assert property (p_rst_pull) else $error("reset line not pulled");

    property p_cfg_pulse;
        @(posedge CLOCK) disable iff (!RST_N) RECONFIGURE_CMD |=> CONFIG_PULSE_N_OE [*8];
    endproperty
    a_cfg_pulse: assert property (p_cfg_pulse) else $error("config pulse too short");

    property p_rev_load;
        @(posedge CLOCK) disable iff (!RST_N)
            cf_rise |=> MEM_ADDR == rev_start($past(rev_pick));
    endproperty
    a_rev_load: assert property (p_rev_load) else $error("revision start not loaded");

    property p_isp_block;
        @(posedge CLOCK) disable iff (!RST_N)
            ISP_MODE_ACTIVE && !ISP_CLAMPED |-> !SERIAL_DATA_LINE_OE ##1 $stable(dout_q) || cf_rise;
    endproperty
    a_isp_block: assert property (p_isp_block) else $error("output during programming");

    property p_adv_gate;
        @(posedge CLOCK) disable iff (!RST_N)
            $changed(dout_q) |-> $past(src_edge && !cs_n_s && oe_s && cf_s && !ISP_MODE_ACTIVE);
    endproperty
    a_adv_gate: assert property (p_adv_gate) else $error("byte advanced without a qualified edge");

    property p_osc_pick;
        @(posedge CLOCK) disable iff (!RST_N)
            advance && USE_INTERNAL_OSC |-> $rose(osc_q);
    endproperty
    a_osc_pick: assert property (p_osc_pick) else $error("advance not from the oscillator");

    property p_cascade;
        @(posedge CLOCK) disable iff (!RST_N)
            !CASCADE_ENABLE_OUT_N |-> !cs_n_s && oe_s && tc_pass_q;
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade output low too early");

    property p_clk_float;
        @(posedge CLOCK) disable iff (!RST_N)
            CFG_CLOCK_OUT_OE |-> !cs_n_s && oe_s;
    endproperty
    a_clk_float: assert property (p_clk_float) else $error("clock output driven while disabled");

    property p_serial_only;
        @(posedge CLOCK) disable iff (!RST_N)
            drive && !PARALLEL_MODE |-> SERIAL_DATA_LINE_OE && UPPER_DATA_LINES_OE == 7'h00;
    endproperty
    a_serial_only: assert property (p_serial_only) else $error("serial mode lines wrong");
endmodule : cprc_readout

// ---- bench/cprc_far_port.sv ----
/*
 * Model of the configuration port of the attached logic device.
 * Assumes pull-ups on both open-drain lines and a 160 ns link clock.
 */
`timescale 1ns/100ps
module cprc_far_port (
    input  wire logic clock,
    input  wire logic oe_rst_oe,
    input  wire logic cf_oe,
    output logic      cfg_clk,
    output logic      ce_n,
    output logic      busy,
    output logic      oe_rst_line,
    output logic      cf_line
);
    logic pull_cf = 1'b0;
    initial begin
        cfg_clk = 1'b0;
        ce_n = 1'b1;
        busy = 1'b0;
    end
    // Released lines read high through their pull-ups.
    assign oe_rst_line = ~oe_rst_oe;
    assign cf_line     = ~(cf_oe | pull_cf);
    // The link clock stands low between bursts.
    task automatic clk_edges(input int n);
        repeat (n) begin
            #80 cfg_clk = 1'b1;
            #80 cfg_clk = 1'b0;
        end
    endtask : clk_edges
    task automatic cf_pulse();
        pull_cf = 1'b1;
        #500 pull_cf = 1'b0;
        #300;
    endtask : cf_pulse
    task automatic set_ce(input logic v);
        @(posedge clock) ce_n <= v;
    endtask : set_ce
    task automatic set_busy(input logic v);
        @(posedge clock) busy <= v;
    endtask : set_busy
endmodule : cprc_far_port

// ---- bench/config_prom_readout_control_tb.sv ----
/*
 * Self-checking bench of the readout control.
 * Assumes the memory array answers combinationally; its pattern is built here.
 */
`timescale 1ns/100ps
module config_prom_readout_control_tb;
    import cprc_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0, ext_en = 1'b0, use_osc = 1'b0, par = 1'b1;
    logic        isp = 1'b0, recfg = 1'b0, clamp = 1'b0, clk_en = 1'b1;
    logic [7:0]  exp8;
    wire         clko;
    logic [1:0]  pick = 2'b00, int_pick = 2'b00;
    logic [15:0] tc = 16'h0FFF, a;
    int          bad_count = 0, comparisons = 0;
    wire         ck, ce_n, busy, oer, cf, oer_oe, cf_oe, sd, sd_oe, clko_oe, casc_n;
    wire [6:0]   ud, ud_oe;
    wire [15:0]  mem_addr;
    wire [7:0]   seen = {ud, sd};
    function automatic logic [7:0] pat(input logic [15:0] x);
        return {x[11:8], x[3:0]};
    endfunction : pat
    initial begin
        forever #5 clock = ~clock;
    end
    cprc_far_port far (.clock(clock), .oe_rst_oe(oer_oe), .cf_oe(cf_oe), .cfg_clk(ck), .ce_n(ce_n),
        .busy(busy), .oe_rst_line(oer), .cf_line(cf));
    cprc_readout dut (.CLOCK(clock), .RST_N(rst_n), .CFG_CLK(ck), .CHIP_SELECT_N(ce_n), .BUSY(busy),
        .OE_RESET_N_IN(oer), .OE_RESET_N_OUT(), .OE_RESET_N_OE(oer_oe), .CONFIG_PULSE_N_IN(cf),
        .CONFIG_PULSE_N_OUT(), .CONFIG_PULSE_N_OE(cf_oe), .EXTERNAL_REV_PICK_ENABLE(ext_en),
        .REVISION_PICK_BIT0(pick[0]), .REVISION_PICK_BIT1(pick[1]), .INTERNAL_REV_PICK(int_pick),
        .USE_INTERNAL_OSC(use_osc), .PARALLEL_MODE(par), .CFG_CLOCK_OUT_ENABLE(clk_en), .ISP_MODE_ACTIVE(isp),
        .ISP_CLAMPED(clamp), .RECONFIGURE_CMD(recfg), .TERMINAL_COUNT(tc), .MEM_ADDR(mem_addr),
        .MEM_DATA(pat(mem_addr)), .SERIAL_DATA_LINE_OUT(sd), .SERIAL_DATA_LINE_OE(sd_oe),
        .UPPER_DATA_LINES_OUT(ud), .UPPER_DATA_LINES_OE(ud_oe), .CFG_CLOCK_OUT(clko),
        .CFG_CLOCK_OUT_OE(clko_oe), .CASCADE_ENABLE_OUT_N(casc_n));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic t_reset_standby();
        cyc(2);
        check("reset pull", 16'h0001, {15'h0000, oer_oe});
        check("data oe in reset", 16'h0000, {8'h00, ud_oe, sd_oe});
        cyc(30);
        check("reset released", 16'h0000, {15'h0000, oer_oe});
        check("standby oe", 16'h0000, {7'h00, clko_oe, ud_oe, sd_oe});
        far.set_ce(1'b0);
        cyc(10);
    endtask : t_reset_standby
    task automatic t_revisions();
        for (int r = 0; r < 4; r++) begin
            ext_en <= (r == 3);
            pick <= r[1:0];
            int_pick <= r[1:0];
            cyc(2);
            far.cf_pulse();
            far.clk_edges(1);
            check("revision start byte", {8'h00, 2'(r), 6'h00}, {8'h00, seen});
            check("parallel oe", 16'h01FF, {7'h00, clko_oe, ud_oe, sd_oe});
        end
        a = REV3_START;
    endtask : t_revisions
    task automatic t_busy();
        far.clk_edges(1);
        check("advance", {8'h00, pat(a + 16'h0001)}, {8'h00, seen});
        far.set_busy(1'b1);
        cyc(5);
        far.clk_edges(3);
        check("busy hold", {8'h00, pat(a + 16'h0001)}, {8'h00, seen});
        far.set_busy(1'b0);
        cyc(5);
        far.clk_edges(1);
        check("after busy", {8'h00, pat(a + 16'h0002)}, {8'h00, seen});
        a = a + 16'h0002;
    endtask : t_busy
    task automatic t_serial_isp();
        par <= 1'b0;
        cyc(6);
        check("serial oe", 16'h0001, {8'h00, ud_oe, sd_oe});
        far.clk_edges(1);
        exp8 = pat(a + 16'h0001);
        check("serial bit", {15'h0000, exp8[0]}, {15'h0000, sd});
        par <= 1'b1;
        isp <= 1'b1;
        cyc(6);
        check("isp oe", 16'h0000, {8'h00, ud_oe, sd_oe});
        clamp <= 1'b1;
        clk_en <= 1'b0;
        cyc(2);
        check("clamped oe", 16'h00FF, {8'h00, ud_oe, sd_oe});
        check("cfg_clock_out off", 16'h0000, {14'h0000, clko_oe, clko});
        clamp <= 1'b0;
        clk_en <= 1'b1;
        cyc(2);
        far.clk_edges(2);
        isp <= 1'b0;
        cyc(6);
        far.clk_edges(1);
        check("isp no advance", {8'h00, pat(a + 16'h0002)}, {8'h00, seen});
    endtask : t_serial_isp
    task automatic t_osc_reconfig();
        use_osc <= 1'b1;
        cyc(200);
        comparisons++;
        if (seen === pat(a + 16'h0002)) begin
            bad_count++;
            $display("FAIL oscillator advance expected change seen %h", seen);
        end
        use_osc <= 1'b0;
        ext_en <= 1'b0;
        pick <= 2'b01;
        tc <= REV1_START + 16'h0001;
        recfg <= 1'b1;
        cyc(1);
        recfg <= 1'b0;
        cyc(3);
        check("pulse on", 16'h0001, {15'h0000, cf_oe});
        cyc(60);
        check("pulse off", 16'h0000, {15'h0000, cf_oe});
        cyc(6);
        far.clk_edges(1);
        check("reload byte", {8'h00, pat(REV1_START)}, {8'h00, seen});
        far.clk_edges(4);
        check("cascade low", 16'h0000, {15'h0000, casc_n});
        far.set_ce(1'b1);
        cyc(8);
        check("cascade high", 16'h0001, {15'h0000, casc_n});
    endtask : t_osc_reconfig
    initial begin
        #500_000;
        bad_count++;
        conclude();
    end
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        t_reset_standby();
        t_revisions();
        t_busy();
        t_serial_isp();
        t_osc_reconfig();
        conclude();
    end
endmodule : config_prom_readout_control_tb
